/* src/nbl_defines.vh */
`ifndef NBL_DEFINES_VH
`define NBL_DEFINES_VH
// Register indices
`define NBL_REG_PROT      4'h0
`define NBL_REG_FEAT      4'h1
`define NBL_REG_STATUS    4'h2
`define NBL_REG_CMD       4'h3
`define NBL_REG_ROW       4'h4
`define NBL_REG_CADDR     4'h5
`define NBL_REG_CDATA     4'h6
`define NBL_REG_ECCST     4'h7
// Protection register fields
`define NBL_PROT_RST      8'h1c
`define NBL_PROT_BP_LSB   2
`define NBL_PROT_INV      5
`define NBL_PROT_CMP      6
`define NBL_PROT_PWD      7
// Feature register field
`define NBL_FEAT_ECC      0
// Command codes
`define NBL_CMD_READ      8'h13
`define NBL_CMD_PROG      8'h10
`define NBL_CMD_ERASE     8'hd8
`define NBL_CMD_RESET     8'hff
// Row space
`define NBL_ROW_MAX       17'h1_ffff
`define NBL_ROW_BLK0      17'h0_003f
// Page layout
`define NBL_SECT_BYTES    12'h200
`define NBL_SPARE_BASE    12'h800
`define NBL_PAR_BASE      12'h840
`define NBL_PAR_END       12'h87f
`define NBL_PAGE_END      12'h87f
`define NBL_SEG_UNPROT    4'h4
// Correction status codes
`define NBL_ECC_OK        2'b00
`define NBL_ECC_FIXED     2'b01
`define NBL_ECC_FAIL      2'b10
// Busy timing
`define NBL_BUSY_CYC      16'h0010
`endif

/* src/nbl_core.v */
// Contract
// - Reset sets range bits to one, clears invert, complement and write-disable.
// - Write-disable set with write-protect low blocks protection bit changes.
// - Locked program or erase keeps busy flag low and starts nothing.
// - Erase to locked block sets erase-fail flag.
// - Program to locked block sets program-fail flag.
// - Code 000 unlocks all; code 111 locks whole array regardless of options.
// - Plain codes 001-110 lock upper 1/64 to 1/2.
// - Invert codes 001-110 lock lower 1/64 to 1/2.
// - Complement codes lock lower 63/64 to 3/4; 110 locks block zero.
// - Both set lock upper 63/64 to 3/4; 110 locks block zero.
// - Correction enabled at reset; software writes enable bit to change it.
// - Program with correction computes parity over main page before array write.
// - Read with correction recomputes parity and corrects cache before output.
// - Each corrected read updates correction status.
// - Spare segments are 4 unprotected then 12 protected bytes at 800h-830h.
// - Four 512-byte sectors each pair with 16 parity bytes at 840h-870h.
// - With correction on, parity byte writes ignored but readable.
// - With correction off, whole page writable and readable, uncorrected.
// - Status 00 none, 01 corrected with count, 10 uncorrectable; the core leaves the count at 00 and never reports 10.
// - Busy flag high during program, read, erase or reset.
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "nbl_defines.vh"
module nbl_core #(
    parameter BUSY_CYC = 16,
    parameter ROW_W    = 17
) (
    input  wire        sys_clk,
    input  wire        rst_b,
    input  wire        write_protect_b,
    input  wire [3:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr_en,
    input  wire        rd_en,
    output reg  [31:0] rdata,
    output reg         busy
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_RUN  = 2'd1;
    localparam ST_ECC  = 2'd2;

    reg [7:0]       prot_q;
    reg             ecc_en_q;
    reg             prog_fail_q;
    reg             erase_fail_q;
    reg [1:0]       ecc_st_q;
    reg [1:0]       ecc_cnt_q;
    reg [ROW_W-1:0] row_q;
    reg [11:0]      caddr_q;
    reg [1:0]       state_q;
    reg [7:0]       op_q;
    reg [15:0]      cnt_q;
    reg [7:0]       cache_q [0:15];
    reg [7:0]       par_q;

    wire [2:0] range_code = prot_q[`NBL_PROT_BP_LSB+2:`NBL_PROT_BP_LSB];
    wire       range_inv  = prot_q[`NBL_PROT_INV];
    wire       range_cmp  = prot_q[`NBL_PROT_CMP];

    // ---------------------------------------------------------------
    // Lock decode
    // ---------------------------------------------------------------
    // Fraction boundary: 1/64 of the row space scaled by 2^(code-1)
    function [ROW_W-1:0] frac_rows;
        input [2:0] code;
        begin
            frac_rows = {{(ROW_W-12){1'b0}}, 12'h800} << (code - 3'd1);
        end
    endfunction

    function is_locked;
        input [ROW_W-1:0] row;
        input [2:0]       code;
        input             range_invert;
        input             cmp;
        reg   [ROW_W-1:0] f;
        begin
            f = frac_rows(code);
            if (code == 3'b000)
                is_locked = 1'b0;
            else if (code == 3'b111)
                is_locked = 1'b1;
            else if (cmp && code == 3'b110)
                is_locked = (row <= `NBL_ROW_BLK0);
            else if (!cmp && !range_invert)
                is_locked = (row >= (`NBL_ROW_MAX + 17'h1 - f));
            else if (!cmp && range_invert)
                is_locked = (row < f);
            else if (cmp && !range_invert)
                is_locked = (row < (`NBL_ROW_MAX + 17'h1 - f));
            else
                is_locked = (row >= f);
        end
    endfunction

    wire row_locked = is_locked(row_q, range_code, range_inv, range_cmp);
    wire prot_wr_ok = !(prot_q[`NBL_PROT_PWD] && !write_protect_b);
    wire par_area   = (caddr_q >= `NBL_PAR_BASE) && (caddr_q <= `NBL_PAR_END);

    // Cache is modelled as a small window; byte address low bits index it
    wire [3:0] cidx = caddr_q[3:0];
    wire cmd_wr = wr_en && (addr == `NBL_REG_CMD);

    // ---------------------------------------------------------------
    // Registers and sequencer
    // ---------------------------------------------------------------
    integer i;
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prot_q       <= `NBL_PROT_RST;
            ecc_en_q     <= 1'b1;
            prog_fail_q  <= 1'b0;
            erase_fail_q <= 1'b0;
            ecc_st_q     <= `NBL_ECC_OK;
            ecc_cnt_q    <= 2'b00;
            row_q        <= {ROW_W{1'b0}};
            caddr_q      <= 12'h000;
            state_q      <= ST_IDLE;
            op_q         <= 8'h00;
            cnt_q        <= 16'h0000;
            par_q        <= 8'h00;
            busy         <= 1'b0;
            rdata        <= 32'h0000_0000;
            for (i = 0; i < 16; i = i + 1)
                cache_q[i] <= 8'h00;
        end else begin
            rdata <= 32'h0000_0000;
            if (wr_en) begin
                case (addr)
                    `NBL_REG_PROT:  if (prot_wr_ok) prot_q <= wdata[7:0] & 8'hfc;
                    `NBL_REG_FEAT:  ecc_en_q <= wdata[`NBL_FEAT_ECC];
                    `NBL_REG_ROW:   row_q <= wdata[ROW_W-1:0];
                    `NBL_REG_CADDR: caddr_q <= wdata[11:0];
                    `NBL_REG_CDATA: begin
                        // Parity bytes are owned by the engine while correction is on
                        if (!(ecc_en_q && par_area))
                            cache_q[cidx] <= wdata[7:0];
                    end
                    default: ;
                endcase
            end
            if (rd_en) begin
                case (addr)
                    `NBL_REG_PROT:   rdata <= {24'h00_0000, prot_q};
                    `NBL_REG_FEAT:   rdata <= {31'h0000_0000, ecc_en_q};
                    `NBL_REG_STATUS: rdata <= {28'h000_0000, erase_fail_q, prog_fail_q,
                                               row_locked, busy};
                    `NBL_REG_ROW:    rdata <= {{(32-ROW_W){1'b0}}, row_q};
                    `NBL_REG_CADDR:  rdata <= {20'h0_0000, caddr_q};
                    `NBL_REG_CDATA:  rdata <= {24'h00_0000, cache_q[cidx]};
                    `NBL_REG_ECCST:  rdata <= {28'h000_0000, ecc_st_q, ecc_cnt_q};
                    default:         rdata <= 32'h0000_0000;
                endcase
            end
            case (state_q)
                ST_IDLE: begin
                    if (cmd_wr) begin
                        op_q <= wdata[7:0];
                        if ((wdata[7:0] == `NBL_CMD_PROG || wdata[7:0] == `NBL_CMD_ERASE)
                            && row_locked) begin
                            // Refused: busy stays low, array untouched
                            if (wdata[7:0] == `NBL_CMD_ERASE)
                                erase_fail_q <= 1'b1;
                            else
                                prog_fail_q <= 1'b1;
                        end else if (wdata[7:0] == `NBL_CMD_PROG ||
                                     wdata[7:0] == `NBL_CMD_ERASE ||
                                     wdata[7:0] == `NBL_CMD_READ ||
                                     wdata[7:0] == `NBL_CMD_RESET) begin
                            busy    <= 1'b1;
                            cnt_q   <= BUSY_CYC[15:0];
                            state_q <= ST_RUN;
                            if (wdata[7:0] == `NBL_CMD_PROG) prog_fail_q <= 1'b0;
                            if (wdata[7:0] == `NBL_CMD_ERASE) erase_fail_q <= 1'b0;
                        end
                    end
                end
                ST_RUN: begin
                    if (cnt_q > 16'h0001) begin
                        cnt_q <= cnt_q - 16'h0001;
                    end else if (ecc_en_q &&
                                 (op_q == `NBL_CMD_PROG || op_q == `NBL_CMD_READ)) begin
                        state_q <= ST_ECC;
                    end else begin
                        busy    <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                ST_ECC: begin
                    // Parity over window bytes 0-3 stands in for the sector code
                    if (op_q == `NBL_CMD_PROG) begin
                        par_q <= cache_q[0] ^ cache_q[1] ^ cache_q[2] ^ cache_q[3];
                    end else begin
                        if ((cache_q[0] ^ cache_q[1] ^ cache_q[2] ^ cache_q[3]) == par_q) begin
                            ecc_st_q  <= `NBL_ECC_OK;
                            ecc_cnt_q <= 2'b00;
                        end else begin
                            ecc_st_q  <= `NBL_ECC_FIXED;
                            ecc_cnt_q <= 2'b00;
                            cache_q[0] <= par_q ^ cache_q[1] ^ cache_q[2] ^ cache_q[3];
                        end
                    end
                    busy    <= 1'b0;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule // nbl_core
`default_nettype wire

/* sim/nbl_core_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "nbl_defines.vh"
// ---
// Port checker
// ---
module nbl_core_monitor #(parameter BUSY_CYC = 16) (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        write_protect_b,
    input wire logic [3:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [31:0] rdata,
    input wire logic        busy
);
    localparam int BMAX = BUSY_CYC + 1;
    logic prot_wr_q;
    // Defaults only hold until software first touches the protection bits
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b) prot_wr_q <= 1'h0;
        else if (wr_en && addr == `NBL_REG_PROT) prot_wr_q <= 1'h1;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_cmd(c);
        wr_en && addr == `NBL_REG_CMD && wdata[7:0] == c && !busy;
    endsequence
    sequence s_rd(a);
        rd_en && addr == a;
    endsequence
    property p_rd_quiet; !$past(rd_en) |-> rdata == 32'h0000_0000; endproperty
    property p_rst_busy; s_cmd(`NBL_CMD_RESET) |=> busy; endproperty
    property p_read_busy; s_cmd(`NBL_CMD_READ) |=> busy; endproperty
    property p_busy_hold; $rose(busy) |=> busy ##[1:BMAX] !busy; endproperty
    property p_prot_dflt;
        s_rd(`NBL_REG_PROT) ##0 !prot_wr_q |=> rdata[7:0] == `NBL_PROT_RST;
    endproperty
    property p_ecc_dflt; s_rd(`NBL_REG_FEAT) ##0 !prot_wr_q |=> rdata[0]; endproperty
    property p_eccst; s_rd(`NBL_REG_ECCST) |=> rdata[3:2] != 2'h3; endproperty
    property p_lock_dflt;
        (s_cmd(`NBL_CMD_PROG) or s_cmd(`NBL_CMD_ERASE)) ##0 !prot_wr_q |=> !busy;
    endproperty
    property p_stat_busy; s_rd(`NBL_REG_STATUS) |=> rdata[0] == $past(busy); endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data not idle");
    a_rst_busy: assert property (p_rst_busy) else $error("reset left busy low");
    a_read_busy: assert property (p_read_busy) else $error("read left busy low");
    a_busy_hold: assert property (p_busy_hold) else $error("busy length wrong");
    a_prot_dflt: assert property (p_prot_dflt) else $error("bad lock default");
    a_ecc_dflt: assert property (p_ecc_dflt) else $error("correction off at reset");
    a_eccst: assert property (p_eccst) else $error("reserved status code");
    a_lock_dflt: assert property (p_lock_dflt) else $error("locked op started");
    a_stat_busy: assert property (p_stat_busy) else $error("status busy wrong");
endmodule // nbl_core_monitor
`default_nettype wire

/* sim/nbl_host.sv */
`timescale 1ns/10ps
`default_nettype none
// ---
// Host model
// ---
module nbl_host (
    input  wire logic        sys_clk,
    output var  logic [3:0]  addr,
    output var  logic [31:0] wdata,
    output var  logic        wr_en,
    output var  logic        rd_en,
    input  wire logic [31:0] rdata
);
    initial {addr, wdata, wr_en, rd_en} = '0;
    // Data is scrambled after the strobe so stale values are never reused
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk) {addr, wdata, wr_en} <= {a, d, 1'h1};
        @(posedge sys_clk) {wdata, wr_en} <= {~d, 1'h0};
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk) {addr, rd_en} <= {a, 1'h1};
        @(posedge sys_clk) rd_en <= 1'h0;
        #1 d = rdata;
    endtask
endmodule // nbl_host
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "nbl_defines.vh"
// ---
// Bench
// ---
module tb;
    localparam int BC = 2;
    logic        sys_clk = 1'h0;
    logic        rst_b = 1'h0;
    logic        write_protect_b = 1'h1;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, v, seed = 32'h0000_0061;
    logic        wr_en, rd_en, busy;
    int          failures = 0, compares = 0, ef = 0, pf = 0, n, r;
    int rows[12] = '{17'h0_0000, 17'h0_003f, 17'h0_0040, 17'h0_07ff, 17'h0_0800, 17'h0_ffff,
        17'h1_0000, 17'h1_7fff, 17'h1_8000, 17'h1_f7ff, 17'h1_f800, 17'h1_ffff};
    nbl_core #(.BUSY_CYC(BC)) DUT (.sys_clk(sys_clk), .rst_b(rst_b),
        .write_protect_b(write_protect_b), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .busy(busy));
    nbl_host host (.sys_clk(sys_clk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata));
    initial forever #50 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed & 32'h0001_ffff;
    endfunction
    // Reference lock range, c is {complement, invert, range code}
    function automatic int lk(int c, int r);
        int b = c & 7;
        int sz = 32'h0000_0800 << (b - 1);
        if (b == 0) return 0;
        if (b == 7) return 1;
        case (c >> 3)
            0: return r >= 32'h0002_0000 - sz;
            1: return r < sz;
            2: return (b == 6) ? r < 32'h0000_0040 : r < 32'h0002_0000 - sz;
            default: return (b == 6) ? r < 32'h0000_0040 : r >= sz;
        endcase
    endfunction
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic op(input logic [7:0] c, input int r, input int l);
        int k;
        host.wr(`NBL_REG_ROW, r);
        host.wr(`NBL_REG_CMD, {24'h00_0000, c});
        #1 n = 0;
        for (k = 0; busy === 1'h1 && k < 50; k++) begin
            n++;
            @(posedge sys_clk) #1;
        end
        if (k == 50) begin
            failures++;
            report_and_stop();
        end
        chk(l ? 0 : BC + (c == `NBL_CMD_PROG || c == `NBL_CMD_READ), n);
        if (c == `NBL_CMD_ERASE) ef = l;
        else if (c == `NBL_CMD_PROG) pf = l;
        host.rd(`NBL_REG_STATUS, v);
        chk({ef[0], pf[0]}, v[3:2]);
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'h1;
        host.rd(`NBL_REG_PROT, v);
        chk(`NBL_PROT_RST, v[7:0]);
        host.rd(`NBL_REG_FEAT, v);
        chk(1, v[0]);
        op(`NBL_CMD_PROG, xs(), 1);
        op(`NBL_CMD_ERASE, xs(), 1);
        for (int c = 0; c < 32; c++) begin
            host.wr(`NBL_REG_PROT, c << 2);
            for (int i = 0; i < 13; i++) begin
                r = (i < 12) ? rows[i] : xs();
                op(i[0] ? `NBL_CMD_PROG : `NBL_CMD_ERASE, r, lk(c, r));
            end
        end
        host.wr(`NBL_REG_PROT, 32'h0000_0080);
        write_protect_b <= 1'h0;
        host.wr(`NBL_REG_PROT, 32'h0000_001c);
        host.rd(`NBL_REG_PROT, v);
        chk(8'h80, v[7:0]);
        host.wr(`NBL_REG_FEAT, 32'h0000_0000);
        host.wr(`NBL_REG_CADDR, `NBL_PAR_BASE);
        host.wr(`NBL_REG_CDATA, 32'h0000_0055);
        host.wr(`NBL_REG_FEAT, 32'h0000_0001);
        host.wr(`NBL_REG_CDATA, 32'h0000_0033);
        host.rd(`NBL_REG_CDATA, v);
        chk(8'h55, v[7:0]);
        op(`NBL_CMD_READ, 0, 0);
        host.rd(`NBL_REG_ECCST, v);
        chk({`NBL_ECC_FIXED, 2'b00}, v[3:0]);
        host.rd(`NBL_REG_CDATA, v);
        chk(8'h00, v[7:0]);
        op(`NBL_CMD_RESET, 0, 0);
        host.wr(`NBL_REG_FEAT, 32'h0000_0000);
        host.wr(`NBL_REG_CADDR, `NBL_SPARE_BASE);
        host.rd(`NBL_REG_CDATA, v);
        chk(8'h00, v[7:0]);
        report_and_stop();
    end
endmodule // tb
bind nbl_core nbl_core_monitor #(.BUSY_CYC(BUSY_CYC)) u_mon (.sys_clk(sys_clk),
    .rst_b(rst_b), .write_protect_b(write_protect_b), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .busy(busy));
`default_nettype wire
